// [verilog/status_flags_pkg.sv]
// constants and types shared by the device status flag logic
package status_flags_pkg;

   // ************************************************************
   // register access
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] MAIN_STATUS_ADDR  = 8'h01;
   localparam logic [ADDR_W-1:0] SUPPLY_FAULT_ADDR = 8'h02;

   // ************************************************************
   // main status register fields
   // ************************************************************
   localparam int MAIN_INIT_BIT     = 0;
   localparam int MAIN_RESET_BIT    = 1;
   localparam int MAIN_TESTMODE_BIT = 2;
   localparam int MAIN_SUPPLY_BIT   = 3;
   localparam int MAIN_MEMTEMP_BIT  = 4;
   localparam int MAIN_COMM_BIT     = 5;
   localparam int MAIN_RSVD_BIT     = 6;
   localparam int MAIN_DSP_BIT      = 7;
   localparam logic MAIN_RESET_RST  = 1'b1;

   // ************************************************************
   // supply fault register fields
   // ************************************************************
   localparam int SUP_LOW_BIT  = 7;
   localparam int SUP_AREG_BIT = 3;
   localparam int SUP_DREG_BIT = 2;
   localparam int SUP_PREG_BIT = 1;
   localparam int SUP_SEAL_BIT = 0;
   localparam int NUM_FAULTS   = 5;
   localparam logic [NUM_FAULTS-1:0] FAULT_RST = 5'h00;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_MHZ  = 250;
   localparam int TICK_US  = 1;
   localparam int TICK_CYC = CLK_MHZ * TICK_US;
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
   localparam int TMR_W    = 16;
   localparam int DEF_RECOV_US      = 100;
   localparam int DEF_DATA_VALID_US = 1000;

   // ************************************************************
   // initialization sequence
   // ************************************************************
   typedef enum logic [1:0] {
      INIT_BOOT,
      INIT_WAIT,
      INIT_DONE
   } init_state_t;

endpackage

// [verilog/tick_timer_if.sv]
// interface between a controller and a tick-driven countdown timer
`timescale 1ns/10ps
`default_nettype none

interface tick_timer_if;
   import status_flags_pkg::*;

   logic             load;
   logic             tick;
   logic [TMR_W-1:0] load_val;
   logic             busy;

   modport ctl (output load, output tick, output load_val, input busy);
   modport tmr (input load, input tick, input load_val, output busy);

endinterface

`default_nettype wire

// [verilog/tick_timer.sv]
// countdown timer stepped by a shared tick enable
`timescale 1ns/10ps
`default_nettype none

module tick_timer
   import status_flags_pkg::*;
(
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_b,
   // control side
   tick_timer_if.tmr   t
);

   logic [TMR_W-1:0] cnt_q;
   logic [TMR_W-1:0] cnt_d;

   // load wins over counting, so a held load keeps the timer full
   assign cnt_d = t.load                      ? t.load_val :
                  (t.tick && (cnt_q != '0))   ? cnt_q - 16'h0001 :
                                                cnt_q;
   assign t.busy = (cnt_q != '0);

   // counter register
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule

`default_nettype wire

// [verilog/device_status_flags.sv]
// main and supply fault status registers with their flag logic
//
// Function
// [RQ1] set the reset-occurred flag after every device reset
// [RQ2] clear reset-occurred on main status read or status-field transmit
// [RQ3] init flag set after reset, cleared once sensor data is valid
// [RQ4] supply fault bit 7 set when supply is below threshold
// [RQ5] supply fault bit 3 set when analog regulator is out of range
// [RQ6] supply fault bit 2 set when digital regulator is out of range
// [RQ7] supply fault bit 1 set when programming regulator out of range
// [RQ8] supply fault bit 0 set when the edge seal loop is broken
// [RQ9] one shared recovery timer serves every supply fault bit
// [RQ10] any active supply fault reloads the shared recovery timer
// [RQ11] fault-report-off control selects how supply fault bits clear
// [RQ12] host ignores supply fault flags while a reset sequence runs
// [RQ13] main status bit 3 is the OR of all supply fault bits
// [RQ14] both status registers are read-only, readable from either port
// [RQ15] a set in the same cycle as a clearing read keeps the flag
`timescale 1ns/10ps
`default_nettype none

module device_status_flags
   import status_flags_pkg::*;
#(
   parameter int unsigned RECOV_US      = DEF_RECOV_US,
   parameter int unsigned DATA_VALID_US = DEF_DATA_VALID_US
)
(
   // clock and reset
   input  wire logic                          CLK,
   input  wire logic                          RST_B,
   // soft reset request from the reset sequencer
   input  wire logic                          SOFT_RESET,
   // register read port shared by both serial interfaces
   input  wire logic                          RD_EN,
   input  wire logic [status_flags_pkg::ADDR_W-1:0] RD_ADDR,
   output logic      [status_flags_pkg::DATA_W-1:0] RD_DATA,
   output logic                               RD_VALID,
   output logic                               RD_HIT,
   // a data transfer carried the reset error in its status field
   input  wire logic                          STAT_TX_RESET_ACK,
   // supply monitors
   input  wire logic                          SUPPLY_LOW,
   input  wire logic                          ANALOG_REG_OOR,
   input  wire logic                          DIGITAL_REG_OOR,
   input  wire logic                          PROG_REG_OOR,
   input  wire logic                          EDGE_SEAL_BREAK,
   // control bit held in the write lock register
   input  wire logic                          SUPPLY_FAULT_REPORT_OFF,
   // summaries of status kept elsewhere
   input  wire logic                          DSP_FAULT,
   input  wire logic                          COMM_FAULT,
   input  wire logic                          MEMTEMP_FAULT,
   input  wire logic                          TEST_MODE,
   // flag outputs
   output logic                               RESET_OCCURRED,
   output logic                               INIT_IN_PROGRESS,
   output logic                               SUPPLY_ERROR
);

   // ************************************************************
   // timing counts
   // ************************************************************

   // waits are least times, so round up to whole ticks
   localparam logic [TMR_W-1:0] RECOV_TICKS =
      TMR_W'((RECOV_US + TICK_US - 1) / TICK_US);
   localparam logic [TMR_W-1:0] DATA_VALID_TICKS =
      TMR_W'((DATA_VALID_US + TICK_US - 1) / TICK_US);

   // ************************************************************
   // declarations
   // ************************************************************

   logic [7:0]            div_q;
   logic [7:0]            div_d;
   logic                  tick;

   init_state_t           init_q;
   init_state_t           init_d;

   logic                  reset_occurred_flag_q;
   logic                  reset_occurred_flag_d;
   logic                  init_in_progress_flag;

   logic [NUM_FAULTS-1:0] fault_in;
   logic [NUM_FAULTS-1:0] fault_q;
   logic [NUM_FAULTS-1:0] fault_d;
   logic                  any_fault_in;
   logic                  fault_clear;
   logic                  supply_err_sum;

   logic                  rd_main;
   logic                  rd_supply;
   logic                  rd_hit;
   logic [DATA_W-1:0]     main_status_reg;
   logic [DATA_W-1:0]     supply_fault_reg;
   logic [DATA_W-1:0]     rd_mux;

   logic [DATA_W-1:0]     rd_data_q;
   logic                  rd_valid_q;
   logic                  rd_hit_q;
   logic                  reset_out_q;
   logic                  init_out_q;
   logic                  supply_out_q;

   tick_timer_if          recov_t ();
   tick_timer_if          dv_t ();

   // ************************************************************
   // microsecond tick divider
   // ************************************************************

   // one enable pulse per tick keeps both timers on a single clock
   assign tick  = (div_q == TICK_LAST);
   assign div_d = tick ? 8'h00 : div_q + 8'h01;

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         div_q <= 8'h00;
      else
         div_q <= div_d;
   end

   // ************************************************************
   // initialization sequence
   // ************************************************************

   // boot loads the data-valid timer, wait runs it out
   always_comb
   begin
      init_d = init_q;
      unique case (init_q)
         INIT_BOOT: init_d = INIT_WAIT;
         INIT_WAIT: init_d = dv_t.busy ? INIT_WAIT : INIT_DONE;
         INIT_DONE: init_d = INIT_DONE;
      endcase
      if (SOFT_RESET)
         init_d = INIT_BOOT;
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         init_q <= INIT_BOOT;        // [RQ3]
      else
         init_q <= init_d;
   end

   // timer reloads on every boot, so a soft reset restarts the wait
   assign dv_t.load     = (init_q == INIT_BOOT);
   assign dv_t.tick     = tick;
   assign dv_t.load_val = DATA_VALID_TICKS;

   tick_timer u_dv_timer (
      .clk   (CLK),
      .rst_b (RST_B),
      .t     (dv_t)
   );

   // flag stays up until the data-valid wait has expired
   assign init_in_progress_flag = (init_q != INIT_DONE);   // [RQ3]

   // ************************************************************
   // register reads
   // ************************************************************

   // both interfaces arrive through this one port; no write path
   assign rd_main   = RD_EN && (RD_ADDR == MAIN_STATUS_ADDR);   // [RQ14]
   assign rd_supply = RD_EN && (RD_ADDR == SUPPLY_FAULT_ADDR);  // [RQ14]
   assign rd_hit    = rd_main || rd_supply;

   // ************************************************************
   // reset-occurred flag
   // ************************************************************

   // set has priority: a soft reset during a clearing read survives
   assign reset_occurred_flag_d =
      SOFT_RESET                        ? 1'b1 :        // [RQ1] [RQ15]
      (rd_main || STAT_TX_RESET_ACK)    ? 1'b0 :        // [RQ2]
                                          reset_occurred_flag_q;

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         reset_occurred_flag_q <= MAIN_RESET_RST;      // [RQ1]
      else
         reset_occurred_flag_q <= reset_occurred_flag_d;
   end

   // ************************************************************
   // supply fault flags and shared recovery timer
   // ************************************************************

   // monitor inputs in register bit order, high to low
   assign fault_in = {SUPPLY_LOW,        // [RQ4]
                      ANALOG_REG_OOR,    // [RQ5]
                      DIGITAL_REG_OOR,   // [RQ6]
                      PROG_REG_OOR,      // [RQ7]
                      EDGE_SEAL_BREAK};  // [RQ8]
   assign any_fault_in = |fault_in;

   // one timer for all bits, held full while any fault is present
   assign recov_t.load     = any_fault_in;                // [RQ9] [RQ10]
   assign recov_t.tick     = tick;
   assign recov_t.load_val = RECOV_TICKS;

   tick_timer u_recov_timer (
      .clk   (CLK),
      .rst_b (RST_B),
      .t     (recov_t)
   );

   // report on: clear when recovered; report off: also needs a read
   assign fault_clear = !recov_t.busy && !any_fault_in &&
                        (!SUPPLY_FAULT_REPORT_OFF || rd_supply); // [RQ11]

   // an active monitor always wins over the clear
   assign fault_d = fault_in |
                    (fault_clear ? FAULT_RST : fault_q);   // [RQ15]

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         fault_q <= FAULT_RST;
      else
         fault_q <= fault_d;
   end

   // flags can be stale during a reset sequence; the host skips them
   assign supply_err_sum = |fault_q;                        // [RQ13]

   // ************************************************************
   // register images
   // ************************************************************

   always_comb
   begin
      main_status_reg                    = '0;
      main_status_reg[MAIN_INIT_BIT]     = init_in_progress_flag;
      main_status_reg[MAIN_RESET_BIT]    = reset_occurred_flag_q;
      main_status_reg[MAIN_TESTMODE_BIT] = TEST_MODE;
      main_status_reg[MAIN_SUPPLY_BIT]   = supply_err_sum;  // [RQ13]
      main_status_reg[MAIN_MEMTEMP_BIT]  = MEMTEMP_FAULT;
      main_status_reg[MAIN_COMM_BIT]     = COMM_FAULT;
      main_status_reg[MAIN_RSVD_BIT]     = 1'b0;
      main_status_reg[MAIN_DSP_BIT]      = DSP_FAULT;
   end

   // unused bits read as zero
   always_comb
   begin
      supply_fault_reg               = '0;
      supply_fault_reg[SUP_LOW_BIT]  = fault_q[4];
      supply_fault_reg[SUP_AREG_BIT] = fault_q[3];
      supply_fault_reg[SUP_DREG_BIT] = fault_q[2];
      supply_fault_reg[SUP_PREG_BIT] = fault_q[1];
      supply_fault_reg[SUP_SEAL_BIT] = fault_q[0];
   end

   // value captured is the one before any read clear takes effect
   assign rd_mux = rd_main   ? main_status_reg :
                   rd_supply ? supply_fault_reg :
                               '0;

   // ************************************************************
   // read answer and flag outputs
   // ************************************************************

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         rd_data_q  <= '0;
         rd_valid_q <= 1'b0;
         rd_hit_q   <= 1'b0;
      end
      else
      begin
         rd_data_q  <= rd_mux;                              // [RQ14]
         rd_valid_q <= RD_EN;
         rd_hit_q   <= rd_hit;
      end
   end

   // outputs follow the flags one cycle later, from flops
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         reset_out_q  <= 1'b1;
         init_out_q   <= 1'b1;
         supply_out_q <= 1'b0;
      end
      else
      begin
         reset_out_q  <= reset_occurred_flag_q;
         init_out_q   <= init_in_progress_flag;
         supply_out_q <= supply_err_sum;
      end
   end

   assign RD_DATA          = rd_data_q;
   assign RD_VALID         = rd_valid_q;
   assign RD_HIT           = rd_hit_q;
   assign RESET_OCCURRED   = reset_out_q;
   assign INIT_IN_PROGRESS = init_out_q;
   assign SUPPLY_ERROR     = supply_out_q;

endmodule

`default_nettype wire

// [bench/status_flags_sva.sv]
// concurrent checks on the ports of the status flag block
`timescale 1ns/10ps
`default_nettype none

module status_flags_sva
   import status_flags_pkg::*;
#(
   parameter int unsigned RECOV_US      = DEF_RECOV_US,
   parameter int unsigned DATA_VALID_US = DEF_DATA_VALID_US
)
(
   // clock and reset
   input wire logic                                  CLK,
   input wire logic                                  RST_B,
   // requests and monitor levels
   input wire logic                                  SOFT_RESET,
   input wire logic                                  RD_EN,
   input wire logic [status_flags_pkg::ADDR_W-1:0]   RD_ADDR,
   input wire logic                                  STAT_TX_RESET_ACK,
   input wire logic                                  SUPPLY_LOW,
   // design outputs
   input wire logic [status_flags_pkg::DATA_W-1:0]   RD_DATA,
   input wire logic                                  RD_VALID,
   input wire logic                                  RD_HIT,
   input wire logic                                  RESET_OCCURRED,
   input wire logic                                  INIT_IN_PROGRESS,
   input wire logic                                  SUPPLY_ERROR
);
   // ***************************************************
   // read port and flag relations
   // ***************************************************
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   // decoded read kinds; the flag outputs lag the flags by one cycle
   wire logic mapped = (RD_ADDR == MAIN_STATUS_ADDR) ||
                       (RD_ADDR == SUPPLY_FAULT_ADDR);
   sequence main_rd;
      RD_EN && RD_ADDR == MAIN_STATUS_ADDR;
   endsequence
   sequence low_then_rd;
      SUPPLY_LOW ##[1:2] (RD_EN && RD_ADDR == SUPPLY_FAULT_ADDR);
   endsequence

   chk_status_hit:
      assert property (RD_EN && mapped |=> RD_VALID && RD_HIT)
      else $error("status read not answered as a hit");
   chk_miss_zero:
      assert property (RD_EN && !mapped |=>
                       RD_VALID && !RD_HIT && RD_DATA == 8'h00)
      else $error("unmapped read not answered with zero");
   chk_soft_sets_flags:
      assert property (SOFT_RESET |-> ##2 RESET_OCCURRED && INIT_IN_PROGRESS)
      else $error("soft reset did not raise both flags");
   chk_read_clears_flag:
      assert property (main_rd ##0 !SOFT_RESET |-> ##2 !RESET_OCCURRED)
      else $error("main status read left reset flag set");
   chk_ack_clears_flag:
      assert property (STAT_TX_RESET_ACK && !SOFT_RESET |-> ##2 !RESET_OCCURRED)
      else $error("status field transfer left reset flag set");
   chk_read_reset_bit:
      assert property (main_rd |=> RD_DATA[MAIN_RESET_BIT] == RESET_OCCURRED)
      else $error("read reset bit differs from flag");
   chk_read_init_bit:
      assert property (main_rd |=> RD_DATA[MAIN_INIT_BIT] == INIT_IN_PROGRESS)
      else $error("read init bit differs from flag");
   chk_summary_bit:
      assert property (main_rd |=> RD_DATA[MAIN_SUPPLY_BIT] == SUPPLY_ERROR)
      else $error("read summary bit differs from supply error");
   chk_fault_raises:
      assert property (SUPPLY_LOW |-> ##2 SUPPLY_ERROR)
      else $error("supply low did not raise supply error");
   chk_low_reads_set:
      assert property (low_then_rd |=> RD_DATA[SUP_LOW_BIT])
      else $error("supply low bit not seen in read");
endmodule

bind device_status_flags status_flags_sva #(
   .RECOV_US(RECOV_US), .DATA_VALID_US(DATA_VALID_US)
) status_flags_sva_inst (
   .CLK(CLK), .RST_B(RST_B), .SOFT_RESET(SOFT_RESET), .RD_EN(RD_EN),
   .RD_ADDR(RD_ADDR), .STAT_TX_RESET_ACK(STAT_TX_RESET_ACK),
   .SUPPLY_LOW(SUPPLY_LOW), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
   .RD_HIT(RD_HIT), .RESET_OCCURRED(RESET_OCCURRED),
   .INIT_IN_PROGRESS(INIT_IN_PROGRESS), .SUPPLY_ERROR(SUPPLY_ERROR)
);

`default_nettype wire

// [bench/host_model.sv]
// host model that issues single register reads on the read port
`timescale 1ns/10ps
`default_nettype none

module host_model
   import status_flags_pkg::*;
(
   // clock
   input  wire logic                                CLK,
   // read request
   output var logic                                 rd_en,
   output var logic [status_flags_pkg::ADDR_W-1:0]  rd_addr
);
   // idle port at time zero
   initial
   begin
      rd_en   = 1'b0;
      rd_addr = 8'h00;
   end

   // one-cycle strobe launched at the falling edge
   task automatic issue(input logic [ADDR_W-1:0] addr);
      @(negedge CLK);
      rd_en   = 1'b1;
      rd_addr = addr;
      @(negedge CLK);
      rd_en   = 1'b0;
      rd_addr = ~addr; // stale address never looks valid
   endtask
endmodule

`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the device status flag block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import status_flags_pkg::*;

   // short counts keep the run brief; ticks stay 250 cycles
   localparam int RECOV  = 2;
   localparam int DVALID = 3;

   logic              clk, rst_b, soft_reset, stat_ack, report_off;
   logic              rd_en, rd_hit, rd_valid, reset_occ, init_busy, sup_err;
   logic [4:0]        faults; // low, analog, digital, prog, seal
   logic [4:0]        f;
   logic [3:0]        misc;   // dsp, comm, memtemp, test
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic [8:0]        exp_q[$];
   int                error_cnt, comparisons, seed;

   device_status_flags #(.RECOV_US(RECOV), .DATA_VALID_US(DVALID))
   device_status_flags_inst (
      .CLK(clk), .RST_B(rst_b), .SOFT_RESET(soft_reset), .RD_EN(rd_en),
      .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .RD_HIT(rd_hit), .STAT_TX_RESET_ACK(stat_ack),
      .SUPPLY_LOW(faults[4]), .ANALOG_REG_OOR(faults[3]),
      .DIGITAL_REG_OOR(faults[2]), .PROG_REG_OOR(faults[1]),
      .EDGE_SEAL_BREAK(faults[0]), .SUPPLY_FAULT_REPORT_OFF(report_off),
      .DSP_FAULT(misc[3]), .COMM_FAULT(misc[2]), .MEMTEMP_FAULT(misc[1]),
      .TEST_MODE(misc[0]), .RESET_OCCURRED(reset_occ),
      .INIT_IN_PROGRESS(init_busy), .SUPPLY_ERROR(sup_err)
   );
   host_model host_model_inst (.CLK(clk), .rd_en(rd_en), .rd_addr(rd_addr));

   // ***************************************************
   // helpers
   // ***************************************************
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // expected {hit, data} is noted before the host issues the read
   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      exp_q.push_back(e);
      host_model_inst.issue(a);
   endtask

   function automatic logic [8:0] mainv(input logic s, r, i);
      return {1'b1, misc[3], 1'b0, misc[2], misc[1], s, misc[0], r, i};
   endfunction

   function automatic logic [8:0] supv(input logic [4:0] b);
      return {1'b1, b[4], 3'h0, b[3:0]};
   endfunction

   task automatic pulse_fault(input logic [4:0] b);
      @(negedge clk);
      faults = b;
      @(negedge clk);
      faults = 5'h00;
   endtask

   task automatic conclude();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ***************************************************
   // clock, watchdog, result monitor
   // ***************************************************
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // about 9000 cycles expected; a hang is cut at 20000
   initial
   begin
      #80000;
      error_cnt++;
      conclude();
   end

   // registered outputs are settled at the falling edge
   always @(negedge clk)
   begin
      if (rd_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check({rd_hit, rd_data}, 9'h1ff);
         else
            check({rd_hit, rd_data}, exp_q.pop_front());
      end
   end

   // ***************************************************
   // scenarios
   // ***************************************************
   initial
   begin
      seed = 32'h2c7e;
      {rst_b, soft_reset, stat_ack, report_off, faults} = 9'h000;
      misc = 4'($random(seed));
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      rd(MAIN_STATUS_ADDR, mainv(1'b0, 1'b1, 1'b1));
      rd(MAIN_STATUS_ADDR, mainv(1'b0, 1'b0, 1'b1));
      rd(8'h05, 9'h000);
      // soft reset raises the flag; the main status read then sees and clears it
      @(negedge clk);
      soft_reset = 1'b1;
      @(negedge clk);
      soft_reset = 1'b0;
      rd(SUPPLY_FAULT_ADDR, supv(5'h00));
      rd(MAIN_STATUS_ADDR, mainv(1'b0, 1'b1, 1'b1));
      // raise the flag again so only the transfer can clear it
      @(negedge clk);
      soft_reset = 1'b1;
      @(negedge clk);
      soft_reset = 1'b0;
      stat_ack = 1'b1;
      @(negedge clk);
      stat_ack = 1'b0;
      rd(MAIN_STATUS_ADDR, mainv(1'b0, 1'b0, 1'b1));
      // soft reset in the same cycle as the clearing read wins
      fork
         rd(MAIN_STATUS_ADDR, mainv(1'b0, 1'b0, 1'b1));
         begin
            @(negedge clk);
            soft_reset = 1'b1;
            @(negedge clk);
            soft_reset = 1'b0;
         end
      join
      rd(MAIN_STATUS_ADDR, mainv(1'b0, 1'b1, 1'b1));
      // host ignores supply bits until init is over
      for (int i = 0; i < 2000 && init_busy !== 1'b0; i++)
         @(negedge clk);
      misc = 4'($random(seed));
      rd(MAIN_STATUS_ADDR, mainv(1'b0, 1'b0, 1'b0));
      // each monitor sets its own bit, then self-clears
      for (int b = 0; b < 5; b++)
      begin
         f = 5'(1 << b);
         pulse_fault(f);
         rd(SUPPLY_FAULT_ADDR, supv(f));
         rd(MAIN_STATUS_ADDR, mainv(1'b1, 1'b0, 1'b0));
         repeat (1000) @(negedge clk);
         rd(SUPPLY_FAULT_ADDR, supv(5'h00));
      end
      // a later fault reloads the one timer and holds the earlier bit
      // reloads come under two ticks apart, yet the read is past
      // the time at which the first bit alone would have cleared
      pulse_fault(5'h10);
      repeat (240) @(negedge clk);
      pulse_fault(5'h01);
      repeat (240) @(negedge clk);
      pulse_fault(5'h01);
      repeat (240) @(negedge clk);
      rd(SUPPLY_FAULT_ADDR, supv(5'h11));
      repeat (1000) @(negedge clk);
      rd(SUPPLY_FAULT_ADDR, supv(5'h00));
      // report-off mode: bits stay until a read, which still sees them
      report_off = 1'b1;
      f = 5'(1 << ($unsigned($random(seed)) % 5));
      pulse_fault(f);
      repeat (1000) @(negedge clk);
      rd(SUPPLY_FAULT_ADDR, supv(f));
      rd(SUPPLY_FAULT_ADDR, supv(5'h00));
      repeat (4) @(negedge clk);
      if (exp_q.size() != 0)
         check(9'(exp_q.size()), 9'h000);
      conclude();
   end
endmodule

`default_nettype wire
